// ---- src/sfof_map.vh ----
// Register map, reset values, field positions and timing counts
`ifndef SFOF_MAP_VH
`define SFOF_MAP_VH
`define SFOF_IDX_FILT 6'h21
`define SFOF_IDX_VDUR 6'h22
`define SFOF_IDX_HDUR 6'h23
`define SFOF_IDX_POL 6'h24
`define SFOF_IDX_CLK 6'h25
`define SFOF_RST_FILT 8'hCC
`define SFOF_RST_VDUR 8'h04
`define SFOF_RST_HDUR 8'h20
`define SFOF_RST_POL 8'hFE
`define SFOF_RST_CLK 8'h72
`define SFOF_B_SPFILT 7
`define SFOF_B_PLLFILT 6
`define SFOF_B_VFILT 5
`define SFOF_B_VDUR 4
`define SFOF_B_OCMODE 3
`define SFOF_B_OCLEN 2
`define SFOF_B_HPOL 7
`define SFOF_B_VPOL 6
`define SFOF_B_DEPOL 5
`define SFOF_B_FPOL 4
`define SFOF_B_GPOL 3
`define SFOF_F_GSEL 2:1
`define SFOF_B_CINV 0
`define SFOF_F_CSEL 7:6
`define SFOF_F_DRV 5:4
`define SFOF_F_MODE 3:2
`define SFOF_B_PRIEN 1
`define SFOF_B_SECEN 0
`define SFOF_GSEL_GREEN 2'h0
`define SFOF_GSEL_RAW 2'h1
`define SFOF_GSEL_REGEN 2'h2
`define SFOF_GSEL_PLL 2'h3
`define SFOF_CSEL_HALF 2'h0
`define SFOF_CSEL_ONE 2'h1
`define SFOF_CSEL_TWO 2'h2
`define SFOF_CSEL_Q90 2'h3
`define SFOF_MODE_444 2'h0
`define SFOF_MODE_422 2'h1
`define SFOF_MODE_DDR 2'h2
`define SFOF_MODE_12B 2'h3
`define SFOF_DLY_SHORT 5'h0A
`define SFOF_DLY_LONG 5'h10
`define SFOF_MEAS_LEN 3'h6
`endif

// ---- src/sfof_top.v ----
// Sync filter and output formatter with a Wishbone register slave
//
// Implementation choice: register access over Wishbone.
`include "sfof_map.vh"
module sfof_top (
	input wire sys_clk_i,
	input wire reset_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	input wire src_digital_i,
	input wire input_sel_i,
	input wire horiz_sync_input_a_i,
	input wire horiz_sync_input_b_i,
	input wire green_sync_input_a_i,
	input wire green_sync_input_b_i,
	input wire dig_hsync_i,
	input wire regen_hsync_i,
	input wire hsync_window_i,
	input wire vsync_i,
	input wire active_video_flag_i,
	input wire field_i,
	input wire clamp_i,
	input wire clk_half_i,
	input wire clk_one_i,
	input wire clk_two_i,
	input wire clk_q90_i,
	input wire pixel_rep_i,
	input wire link_clk_div_i,
	input wire [7:0] red_i,
	input wire [7:0] green_i,
	input wire [7:0] blue_i,
	output reg hsync_to_pll_o,
	output reg hsync_o,
	output reg vsync_o,
	output reg active_video_flag_o,
	output reg field_o,
	output reg green_channel_sync_o,
	output reg offset_measure_o,
	output wire clk_out_o,
	output reg [1:0] drive_strength_o,
	output reg [1:0] output_mode_o,
	output reg primary_en_o,
	output reg secondary_en_o,
	output reg [7:0] red_o,
	output reg [7:0] green_o,
	output reg [7:0] blue_o
);

// ----------------------------------------
// Register slave
// ----------------------------------------
reg [7:0] filt_ctrl;
reg [7:0] vsync_stretch_length;
reg [7:0] hsync_pulse_width;
reg [7:0] pol_route;
reg [7:0] clk_mode;
reg ack;
reg [7:0] rd_data;
wire [5:0] idx;
wire access;
wire wr_lane;

assign idx = wb_adr_i[7:2];
assign access = wb_cyc_i & wb_stb_i & ~ack;
assign wr_lane = access & wb_we_i & wb_sel_i[0];
assign wb_ack_o = ack;
assign wb_dat_o = {24'h000000, rd_data};

always @(posedge sys_clk_i or posedge reset_i) begin
	if (reset_i) begin
		ack <= 1'b0;
		rd_data <= 8'h00;
		filt_ctrl <= `SFOF_RST_FILT;
		vsync_stretch_length <= `SFOF_RST_VDUR;
		hsync_pulse_width <= `SFOF_RST_HDUR;
		pol_route <= `SFOF_RST_POL;
		clk_mode <= `SFOF_RST_CLK;
	end else begin
		ack <= access;
		if (wr_lane) begin
			case (idx)
				`SFOF_IDX_FILT: filt_ctrl <= wb_dat_i[7:0];
				`SFOF_IDX_VDUR: vsync_stretch_length <= wb_dat_i[7:0];
				`SFOF_IDX_HDUR: hsync_pulse_width <= wb_dat_i[7:0];
				`SFOF_IDX_POL: pol_route <= wb_dat_i[7:0];
				`SFOF_IDX_CLK: clk_mode <= wb_dat_i[7:0];
				default: ;
			endcase
		end
		if (access & ~wb_we_i) begin
			case (idx)
				`SFOF_IDX_FILT: rd_data <= filt_ctrl;
				`SFOF_IDX_VDUR: rd_data <= vsync_stretch_length;
				`SFOF_IDX_HDUR: rd_data <= hsync_pulse_width;
				`SFOF_IDX_POL: rd_data <= pol_route;
				`SFOF_IDX_CLK: rd_data <= clk_mode;
				default: rd_data <= 8'h00;
			endcase
		end
	end
end

// ----------------------------------------
// Sync source selection
// ----------------------------------------
wire raw_hsync;
wire green_sync;
wire pll_hsync;
wire vlogic_hsync;

assign raw_hsync = src_digital_i ? dig_hsync_i :
	(input_sel_i ? horiz_sync_input_b_i : horiz_sync_input_a_i);
assign green_sync = input_sel_i ? green_sync_input_b_i :
	green_sync_input_a_i;
assign pll_hsync = filt_ctrl[`SFOF_B_PLLFILT] ?
	(raw_hsync & hsync_window_i) : raw_hsync;
assign vlogic_hsync = filt_ctrl[`SFOF_B_SPFILT] ? regen_hsync_i : raw_hsync;

reg vh_prev;
reg ph_prev;
reg v_prev;
wire vh_rise;
wire ph_rise;

assign vh_rise = vlogic_hsync & ~vh_prev;
assign ph_rise = pll_hsync & ~ph_prev;

// ----------------------------------------
// Vsync filter and duration
// ----------------------------------------
reg v_pend;
reg v_filt;
reg [7:0] v_lines;
reg v_stretch;
wire v_fall;
wire v_rise;
wire vsync_sel;

assign v_rise = vsync_i & ~v_prev;
assign v_fall = ~vsync_i & v_prev;

always @(posedge sys_clk_i or posedge reset_i) begin
	if (reset_i) begin
		vh_prev <= 1'b0;
		ph_prev <= 1'b0;
		v_prev <= 1'b0;
		v_pend <= 1'b0;
		v_filt <= 1'b0;
		v_lines <= 8'h00;
		v_stretch <= 1'b0;
	end else begin
		vh_prev <= vlogic_hsync;
		ph_prev <= pll_hsync;
		v_prev <= vsync_i;
		if (v_rise) begin
			v_pend <= 1'b1;
		end else if (v_fall) begin
			v_pend <= 1'b0;
		end
		if (vh_rise & v_pend & vsync_i) begin
			v_filt <= 1'b1;
			v_pend <= 1'b0;
		end else if (vh_rise & ~vsync_i) begin
			v_filt <= 1'b0;
		end
		if (vh_rise & v_pend & vsync_i) begin
			v_stretch <= (vsync_stretch_length != 8'h00);
			v_lines <= vsync_stretch_length;
		end else if (vh_rise & v_stretch) begin
			if (v_lines <= 8'h01) begin
				v_stretch <= 1'b0;
				v_lines <= 8'h00;
			end else begin
				v_lines <= v_lines - 8'h01;
			end
		end
	end
end

assign vsync_sel = ~filt_ctrl[`SFOF_B_VFILT] ? vsync_i :
	(filt_ctrl[`SFOF_B_VDUR] ? v_stretch : v_filt);

// ----------------------------------------
// Output hsync width
// ----------------------------------------
reg [7:0] h_cnt;
wire h_active;

always @(posedge sys_clk_i or posedge reset_i) begin
	if (reset_i) begin
		h_cnt <= 8'h00;
	end else if (ph_rise) begin
		h_cnt <= hsync_pulse_width;
	end else if (h_cnt != 8'h00) begin
		h_cnt <= h_cnt - 8'h01;
	end
end

assign h_active = (h_cnt != 8'h00);

// ----------------------------------------
// Offset measurement window
// ----------------------------------------
reg clamp_prev;
reg [4:0] dly_cnt;
reg [2:0] meas_cnt;
wire [4:0] dly_len;

assign dly_len = filt_ctrl[`SFOF_B_OCLEN] ? `SFOF_DLY_LONG : `SFOF_DLY_SHORT;

always @(posedge sys_clk_i or posedge reset_i) begin
	if (reset_i) begin
		clamp_prev <= 1'b0;
		dly_cnt <= 5'h00;
		meas_cnt <= 3'h0;
		offset_measure_o <= 1'b0;
	end else begin
		clamp_prev <= clamp_i;
		if (~filt_ctrl[`SFOF_B_OCMODE]) begin
			dly_cnt <= 5'h00;
			meas_cnt <= 3'h0;
			offset_measure_o <= clamp_i;
		end else begin
			offset_measure_o <= (meas_cnt != 3'h0);
			if (clamp_prev & ~clamp_i) begin
				dly_cnt <= dly_len;
				meas_cnt <= 3'h0;
			end else if (dly_cnt != 5'h00) begin
				dly_cnt <= dly_cnt - 5'h01;
				if (dly_cnt == 5'h01) begin
					meas_cnt <= `SFOF_MEAS_LEN;
				end
			end else if (meas_cnt != 3'h0) begin
				meas_cnt <= meas_cnt - 3'h1;
			end
		end
	end
end

// ----------------------------------------
// Sync outputs
// ----------------------------------------
reg next_green;

always @* begin
	next_green = green_sync;
	case (pol_route[`SFOF_F_GSEL])
		`SFOF_GSEL_GREEN: next_green = green_sync;
		`SFOF_GSEL_RAW: next_green = raw_hsync;
		`SFOF_GSEL_REGEN: next_green = regen_hsync_i;
		`SFOF_GSEL_PLL: next_green = pll_hsync;
		default: next_green = green_sync;
	endcase
end

always @(posedge sys_clk_i or posedge reset_i) begin
	if (reset_i) begin
		hsync_to_pll_o <= 1'b0;
		hsync_o <= 1'b0;
		vsync_o <= 1'b0;
		active_video_flag_o <= 1'b0;
		field_o <= 1'b0;
		green_channel_sync_o <= 1'b0;
	end else begin
		hsync_to_pll_o <= pll_hsync;
		hsync_o <= ~(h_active ^ pol_route[`SFOF_B_HPOL]);
		vsync_o <= ~(vsync_sel ^ pol_route[`SFOF_B_VPOL]);
		active_video_flag_o <= ~(active_video_flag_i ^
			pol_route[`SFOF_B_DEPOL]);
		field_o <= ~(field_i ^ pol_route[`SFOF_B_FPOL]);
		green_channel_sync_o <= src_digital_i ? next_green :
			~(next_green ^ pol_route[`SFOF_B_GPOL]);
	end
end

// ----------------------------------------
// Output clock
// ----------------------------------------
reg [1:0] csel_q;
reg cinv_q;
reg clk_mux;
wire clk_one;

assign clk_one = pixel_rep_i ? link_clk_div_i : clk_one_i;

always @(posedge sys_clk_i or posedge reset_i) begin
	if (reset_i) begin
		csel_q <= `SFOF_CSEL_ONE;
		cinv_q <= 1'b0;
	end else if (~clk_mux) begin
		csel_q <= clk_mode[`SFOF_F_CSEL];
		cinv_q <= pol_route[`SFOF_B_CINV];
	end
end

always @* begin
	clk_mux = clk_one;
	case (csel_q)
		`SFOF_CSEL_HALF: clk_mux = clk_half_i;
		`SFOF_CSEL_ONE: clk_mux = clk_one;
		`SFOF_CSEL_TWO: clk_mux = clk_two_i;
		`SFOF_CSEL_Q90: clk_mux = clk_q90_i;
		default: clk_mux = clk_one;
	endcase
end

assign clk_out_o = clk_mux ^ cinv_q;

// ----------------------------------------
// Pixel formatting
// ----------------------------------------
reg chroma_phase;

always @(posedge sys_clk_i or posedge reset_i) begin
	if (reset_i) begin
		drive_strength_o <= 2'h0;
		output_mode_o <= `SFOF_MODE_444;
		primary_en_o <= 1'b0;
		secondary_en_o <= 1'b0;
		chroma_phase <= 1'b0;
		red_o <= 8'h00;
		green_o <= 8'h00;
		blue_o <= 8'h00;
	end else begin
		drive_strength_o <= clk_mode[`SFOF_F_DRV];
		output_mode_o <= clk_mode[`SFOF_F_MODE];
		primary_en_o <= clk_mode[`SFOF_B_PRIEN];
		secondary_en_o <= clk_mode[`SFOF_B_SECEN];
		chroma_phase <= active_video_flag_i ? ~chroma_phase : 1'b0;
		case (clk_mode[`SFOF_F_MODE])
			`SFOF_MODE_444: begin
				red_o <= red_i;
				green_o <= green_i;
				blue_o <= blue_i;
			end
			`SFOF_MODE_422: begin
				red_o <= chroma_phase ? red_i : blue_i;
				green_o <= green_i;
				blue_o <= chroma_phase ? red_i : blue_i;
			end
			`SFOF_MODE_DDR: begin
				red_o <= red_i;
				green_o <= green_i;
				blue_o <= chroma_phase ? red_i : blue_i;
			end
			`SFOF_MODE_12B: begin
				red_o <= chroma_phase ? red_i : blue_i;
				green_o <= green_i;
				blue_o <= {green_i[3:0], 4'h0};
			end
			default: begin
				red_o <= red_i;
				green_o <= green_i;
				blue_o <= blue_i;
			end
		endcase
	end
end

endmodule // sfof_top

// ---- testbench/sfof_props.sv ----
// Checker for the register bus and the sync output paths
`include "sfof_map.vh"
module sfof_props (
	input wire sys_clk_i,
	input wire reset_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	input wire src_digital_i,
	input wire input_sel_i,
	input wire horiz_sync_input_a_i,
	input wire horiz_sync_input_b_i,
	input wire green_sync_input_a_i,
	input wire green_sync_input_b_i,
	input wire dig_hsync_i,
	input wire regen_hsync_i,
	input wire hsync_window_i,
	input wire vsync_i,
	input wire active_video_flag_i,
	input wire field_i,
	input wire clamp_i,
	input wire hsync_to_pll_o,
	input wire vsync_o,
	input wire active_video_flag_o,
	input wire field_o,
	input wire green_channel_sync_o,
	input wire offset_measure_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] flt;
	logic [7:0] pol;
	wire wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
	wire hs = src_digital_i ? dig_hsync_i :
		input_sel_i ? horiz_sync_input_b_i : horiz_sync_input_a_i;
	wire gs = input_sel_i ? green_sync_input_b_i : green_sync_input_a_i;
	wire src = pol[2] ? regen_hsync_i : pol[1] ? hs : gs;
	wire ginv = !(pol[3] || src_digital_i);
	// Shadow of the filter and polarity registers
	always @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			flt <= `SFOF_RST_FILT;
			pol <= `SFOF_RST_POL;
		end else if (wr && wb_adr_i[7:2] == `SFOF_IDX_FILT) begin
			flt <= wb_dat_i[7:0];
		end else if (wr && wb_adr_i[7:2] == `SFOF_IDX_POL) begin
			pol <= wb_dat_i[7:0];
		end
	end
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	a_ack_answer: assert property
		(wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	a_vsync_pol: assert property
		(!$past(flt[5]) && !$past(flt[4])
		|-> vsync_o == ($past(vsync_i) ~^ $past(pol[6])))
		else $error("vsync polarity wrong");
	a_flag_pol: assert property (active_video_flag_o ==
		($past(active_video_flag_i) ~^ $past(pol[5])))
		else $error("active flag polarity wrong");
	a_field_pol: assert property
		(field_o == ($past(field_i) ~^ $past(pol[4])))
		else $error("field polarity wrong");
	a_green_route: assert property ($past(pol[2:1]) != 2'h3
		|-> green_channel_sync_o == ($past(src) ^ $past(ginv)))
		else $error("green sync route wrong");
	a_green_pll: assert property ($past(pol[2:1]) == 2'h3
		|-> green_channel_sync_o == (hsync_to_pll_o ^ $past(ginv)))
		else $error("green sync not pll hsync");
	a_pll_clip: assert property ($past(flt[6]) && hsync_to_pll_o
		|-> $past(hsync_window_i) && $past(hs))
		else $error("pll hsync outside window");
	a_pll_raw: assert property
		(!$past(flt[6]) |-> hsync_to_pll_o == $past(hs))
		else $error("pll hsync not raw");
	a_meas_len: assert property ($rose(offset_measure_o)
		&& $past(flt[3]) |-> offset_measure_o[*6] ##1 !offset_measure_o)
		else $error("measure window length wrong");
	a_meas_wait: assert property
		($fell(clamp_i) && flt[3] && !flt[2]
		|-> !offset_measure_o[*8] ##1 !offset_measure_o[*4]
		##1 offset_measure_o)
		else $error("short measure delay wrong");
	a_meas_long: assert property
		($fell(clamp_i) && flt[3] && flt[2]
		|-> !offset_measure_o[*8] ##1 !offset_measure_o[*8]
		##1 !offset_measure_o[*2] ##1 offset_measure_o)
		else $error("long measure delay wrong");
	cover property ($rose(offset_measure_o));
	cover property (hsync_to_pll_o && $past(flt[6]));
	cover property (wb_ack_o && !wb_we_i);
endmodule // sfof_props

bind sfof_top sfof_props i_sfof_props (.*);

// ---- testbench/sfof_sink.sv ----
// Downstream sink measuring active hsync and measure pulse widths
module sfof_sink (
	input wire clk_i,
	input wire act_high_i,
	input wire hsync_i,
	input wire meas_i,
	output int hs_width_o,
	output int meas_width_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int hc = 0;
	int mc = 0;
	always @(posedge clk_i) begin
		if (hsync_i === act_high_i) begin
			hc <= hc + 1;
		end else if (hc != 0) begin
			hs_width_o <= hc;
			hc <= 0;
		end
	end
	always @(posedge clk_i) begin
		if (meas_i === 1'b1) begin
			mc <= mc + 1;
		end else if (mc != 0) begin
			meas_width_o <= mc;
			mc <= 0;
		end
	end
endmodule // sfof_sink

// ---- testbench/sfof_top_tb.sv ----
// Self-checking bench for the sync filter and output formatter
`include "sfof_map.vh"
module sfof_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_i, reset_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [7:0] wb_adr_i, red_i, green_i, blue_i, red_o, green_o, blue_o;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic src_digital_i, input_sel_i, horiz_sync_input_a_i;
	logic horiz_sync_input_b_i, green_sync_input_a_i, green_sync_input_b_i;
	logic regen_hsync_i, hsync_window_i, vsync_i, active_video_flag_i;
	logic field_i, clamp_i, clk_half_i, clk_one_i, clk_two_i, clk_q90_i;
	logic pixel_rep_i, link_clk_div_i, hsync_to_pll_o, hsync_o, vsync_o;
	logic active_video_flag_o, field_o, green_channel_sync_o;
	logic offset_measure_o, clk_out_o, primary_en_o, secondary_en_o;
	logic [1:0] drive_strength_o, output_mode_o;
	logic dig_hsync_i;
	logic [23:0] px;
	logic [31:0] seed = 32'h8EB7BA8D;
	logic [7:0] mdl [logic [7:0]];
	logic [7:0] a, d;
	logic hpol = 1'b1;
	int fail_count = 0;
	int cmp_count = 0;
	int hsw, omw, dly, d0, vc;
	sfof_top i_sfof_top (.*);
	sfof_sink i_sfof_sink (.clk_i(sys_clk_i), .act_high_i(hpol),
		.hsync_i(hsync_o), .meas_i(offset_measure_o),
		.hs_width_o(hsw), .meas_width_o(omw));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(logic w, logic [7:0] ad, logic [7:0] dt, logic s);
		@(posedge sys_clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, ad};
		wb_dat_i <= {24'h0, dt};
		wb_sel_i <= {3'h7, s};
		do begin
			@(posedge sys_clk_i);
		end while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		if (!w) chk("rdata", mdl.exists(ad) ? mdl[ad] : 8'h0, wb_dat_o);
		if (w && s && mdl.exists(ad)) mdl[ad] = dt;
	endtask
	task automatic syncs(logic [11:0] v);
		{src_digital_i, input_sel_i, horiz_sync_input_a_i,
			horiz_sync_input_b_i, green_sync_input_a_i,
			green_sync_input_b_i, regen_hsync_i, hsync_window_i,
			vsync_i, active_video_flag_i, field_i, dig_hsync_i} <= v;
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		sys_clk_i = 0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		#125000;
		fail_count++;
		complete_run();
	end
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{src_digital_i, input_sel_i, horiz_sync_input_a_i,
			horiz_sync_input_b_i, green_sync_input_a_i, green_sync_input_b_i,
			regen_hsync_i, hsync_window_i, vsync_i, active_video_flag_i,
			field_i, clamp_i, pixel_rep_i, link_clk_div_i, dig_hsync_i} = '0;
		{clk_half_i, clk_one_i, clk_two_i, clk_q90_i} = '0;
		{red_i, green_i, blue_i} = '0;
		mdl[8'h84] = `SFOF_RST_FILT;
		mdl[8'h88] = `SFOF_RST_VDUR;
		mdl[8'h8C] = `SFOF_RST_HDUR;
		mdl[8'h90] = `SFOF_RST_POL;
		mdl[8'h94] = `SFOF_RST_CLK;
		reset_i = 1;
		repeat (3) @(posedge sys_clk_i);
		reset_i <= 0;
		foreach (mdl[k]) bus(0, k, 8'h0, 1);
		bus(0, 8'hC0, 8'h0, 1);
		for (int i = 0; i < 12; i++) begin
			a = 8'h84 + 8'(4 * (rnd() % 5));
			d = 8'(rnd());
			if (a == 8'h90) d[0] = 0;
			bus(1, a, d, 1'(rnd()));
			bus(0, a, 8'h0, 1);
		end
		for (int i = 0; i < 6; i++) begin
			bus(1, 8'h84, {1'b1, 1'(i), 6'h0C}, 1);
			bus(1, 8'h90, {5'(rnd()), 2'(i), 1'b0}, 1);
			repeat (50) begin
				@(posedge sys_clk_i);
				syncs(12'(rnd()));
				{red_i, green_i, blue_i} <= 24'(rnd());
			end
		end
		syncs(12'h0);
		// Let any pulse left from random sync traffic run out
		repeat (256) @(posedge sys_clk_i);
		bus(1, 8'h84, 8'h8C, 1);
		for (int w = 1; w <= 32; w += 31) begin
			hpol = 1'(rnd());
			bus(1, 8'h90, {hpol, 7'h7E}, 1);
			bus(1, 8'h8C, 8'(w), 1);
			repeat (40) @(posedge sys_clk_i);
			horiz_sync_input_a_i <= 1;
			repeat (3) @(posedge sys_clk_i);
			horiz_sync_input_a_i <= 0;
			repeat (40) @(posedge sys_clk_i);
			chk("hsync width", w, hsw);
		end
		for (int i = 0; i < 4; i++) begin
			bus(1, 8'h94, {4{2'(i)}}, 1);
			@(posedge sys_clk_i);
			{clk_q90_i, clk_two_i, clk_one_i, clk_half_i} <= 4'h1 << i;
			px = 24'(rnd());
			{red_i, green_i, blue_i} <= px;
			@(negedge sys_clk_i);
			chk("clk out", 1, clk_out_o);
			chk("drive", i, drive_strength_o);
			chk("mode", i, output_mode_o);
			chk("enables", i, {primary_en_o, secondary_en_o});
			@(posedge sys_clk_i);
			{clk_q90_i, clk_two_i, clk_one_i, clk_half_i} <= 4'h0;
			@(negedge sys_clk_i);
			chk("green", px[15:8], green_o);
			if (i == 0) chk("pixels", px, {red_o, green_o, blue_o});
		end
		bus(1, 8'h94, 8'h72, 1);
		bus(1, 8'h90, 8'hFF, 1);
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
		chk("clk inverted", 1, clk_out_o);
		@(posedge sys_clk_i);
		{pixel_rep_i, link_clk_div_i} <= 2'b11;
		@(negedge sys_clk_i);
		chk("clk repeated", 0, clk_out_o);
		for (int l = 0; l < 2; l++) begin
			bus(1, 8'h84, {5'h19, 1'(l), 2'h0}, 1);
			clamp_i <= 1;
			repeat (4) @(posedge sys_clk_i);
			clamp_i <= 0;
			dly = 0;
			do begin
				@(posedge sys_clk_i);
				dly++;
			end while (offset_measure_o !== 1'b1 && dly < 40);
			repeat (12) @(posedge sys_clk_i);
			chk("measure length", 6, omw);
			if (l == 0) d0 = dly;
			else chk("delay step", 6, dly - d0);
		end
		// Lines of 8 cycles on regenerated hsync, vsync 4 lines long
		d = 8'(2 + rnd() % 6);
		bus(1, 8'h88, d, 1);
		for (int m = 0; m < 2; m++) begin
			bus(1, 8'h84, {3'h5, 1'(m), 4'h0}, 1);
			vc = 0;
			for (int c = 0; c < 8 * (d + 10); c++) begin
				@(posedge sys_clk_i);
				regen_hsync_i <= (c % 8 < 2);
				vsync_i <= (c >= 16 && c < 48);
				if (c >= 8 && vsync_o === 1'b1) vc++;
			end
			chk("vsync length", m ? 8 * d : 24, vc);
		end
		complete_run();
	end
endmodule // sfof_top_tb
